// [dma_host_model.sv]
// model: host dma controller taking one beat per served request
`timescale 1ns/1ps
`default_nettype none
module dma_host_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // request in, latency knob, beat taken out
   input wire logic req,
   input wire logic [1:0] slow,
   output logic done
);
   logic [1:0] wait_q;
   // a dropped request aborts the wait, so no beat is taken after negation
   always_ff @(posedge clk) begin
      if (!rst_b || !req || done) begin
         wait_q <= slow;
         done <= 1'b0;
      end else if (wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
      end else begin
         done <= 1'b1;
      end
   end
endmodule // dma_host_model
`default_nettype wire

// [host_dma_irq_control_regs.sv]
// host-interface control registers: dma request, command list, interrupts, soft reset
// Functional notes
// R1: mask bit 1 holds off the external dma request; 0 re-enables it.
// R2: dma activity flag reads 1 during a dma transfer, 0 after completion.
// R3: writing 1 to dma stop suspends the dma transfer in progress.
// R4: host writes dma stop after its transfer in no-ack dual mode.
// R5: writing 1 to command-list stop suspends the list transfer in progress.
// R6: command-list activity flag reads 1 during list transfer, 0 after.
// R7: writing 1 to the trigger starts a dma with external request handshake.
// R8: request line stays low while mask is set, even after trigger.
// R9: trigger ignores written 0; hardware clears it when dma completes.
// R10: pending bit reads 1 when raised; writing 0 clears it.
// R11: pending bits 0..4: cmd error, cmd done, vsync, frame sync, sync error.
// R12: pending bits 17:16 are test bits, may be 1 after cmd error.
// R13: a source whose enable bit is 0 does not drive the interrupt.
// R14: enable bits 0..4 gate the same five sources in the same order.
// R15: writing 1 to the soft reset bit performs a software reset.
// R16: no-ack mode: edge request, negated per transfer and while not ready.
// R17: transfer count shows remaining count; 0 means 16,777,216 transfers.
// R18: list start bit begins the list transfer; fifo access blocked meanwhile.
// R19: software reset leaves the memory mode register untouched.
// R20: interrupt output active when any pending bit has its enable set.
// R21: reserved bits read 0 and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module host_dma_irq_control_regs (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // host register access
   input wire logic HOST_RD,
   input wire logic HOST_WR,
   input wire logic [11:0] HOST_ADDR,
   input wire logic [31:0] HOST_WDATA,
   output logic [31:0] HOST_RDATA,
   // external dma handshake
   output logic DMA_REQUEST_LINE,
   input wire logic DMA_XFER_DONE,
   input wire logic DMA_DATA_READY,
   // command list engine
   input wire logic CMD_LIST_DONE,
   output logic CMD_LIST_RUN,
   output logic LIST_FIFO_BLOCK,
   // interrupt sources and output
   input wire logic [4:0] IRQ_EVENTS,
   input wire logic [1:0] IRQ_TEST_EVENTS,
   output logic IRQ_OUT,
   // software reset to the rest of the device
   output logic SOFT_RESET_PULSE
);
   // host access and event views of the ports
   host_regs_pkg::host_access_t acc;
   host_regs_pkg::irq_events_t ev;

   // request sequencer state
   host_regs_pkg::dma_state_t st_q;
   host_regs_pkg::dma_state_t st_d;

   // ready synchroniser
   logic [1:0] ready_sync_q;
   logic ready_s;

   // soft reset strobe and the combined block reset
   logic soft_reset_cmd_q;
   logic rst_all;

   // register contents
   logic mask_q;
   logic trig_q;
   logic dma_act_q;
   logic list_act_q;
   logic [3:0] setup_q;
   logic [23:0] count_q;
   logic [4:0] pend_q;
   logic [1:0] test_q;
   logic [4:0] en_q;

   // read data ahead of its output flop
   logic [31:0] rdata_d;

   // decoded write strobes
   logic wr_mask;
   logic wr_stop;
   logic wr_lstop;
   logic wr_trig;
   logic wr_pend;
   logic wr_en;
   logic wr_soft_reset_cmd;
   logic wr_setup;
   logic wr_count;
   logic wr_lstart;

   // transfer events
   logic dma_end;
   logic beat;

   assign acc = '{rd: HOST_RD, wr: HOST_WR, addr: HOST_ADDR, wdata: HOST_WDATA};
   assign ev = host_regs_pkg::irq_events_t'(IRQ_EVENTS);

   // write strobes per register
   // exact offset match only; aliases would let stray writes hit the command bits
   assign wr_mask = acc.wr && acc.addr == host_regs_pkg::OFS_DMA_REQUEST_MASK;
   assign wr_stop = acc.wr && acc.addr == host_regs_pkg::OFS_DMA_STOP;
   assign wr_lstop = acc.wr && acc.addr == host_regs_pkg::OFS_CMD_LIST_STOP;
   assign wr_trig = acc.wr && acc.addr == host_regs_pkg::OFS_DMA_REQUEST_TRIGGER;
   assign wr_pend = acc.wr && acc.addr == host_regs_pkg::OFS_IRQ_PENDING;
   assign wr_en = acc.wr && acc.addr == host_regs_pkg::OFS_IRQ_ENABLE;
   assign wr_soft_reset_cmd = acc.wr && acc.addr == host_regs_pkg::OFS_SOFT_RESET;
   assign wr_setup = acc.wr && acc.addr == host_regs_pkg::OFS_DMA_SETUP;
   assign wr_count = acc.wr && acc.addr == host_regs_pkg::OFS_TRANSFER_COUNT;
   assign wr_lstart = acc.wr && acc.addr == host_regs_pkg::OFS_CMD_LIST_START;

   // ready input comes from outside logic timing, two flops before use
   // only the second flop feeds logic; the first may still be settling
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         ready_sync_q <= 2'h0;
      end else begin
         ready_sync_q <= {ready_sync_q[0], DMA_DATA_READY};
      end
   end
   assign ready_s = ready_sync_q[1];

   // soft reset strobe, one cycle; clears this block's state too
   // the read data flop is outside this reset, so a read in flight keeps its value
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         soft_reset_cmd_q <= 1'b0;
      end else begin
         soft_reset_cmd_q <= wr_soft_reset_cmd && acc.wdata[0]; // R15
      end
   end
   assign SOFT_RESET_PULSE = soft_reset_cmd_q;
   // memory mode register lives elsewhere and never sees this strobe as a reset
   assign rst_all = !RST_B || soft_reset_cmd_q; // R19

   // dma request mask and setup bits
   always_ff @(posedge CLK) begin
      if (rst_all) begin
         mask_q <= host_regs_pkg::RST_FLAG;
         setup_q <= host_regs_pkg::RST_SETUP;
      end else begin
         if (wr_mask) begin
            mask_q <= acc.wdata[0]; // R1
         end
         if (wr_setup) begin
            setup_q <= acc.wdata[3:0];
         end
      end
   end

   // one transfer beat taken by the host dma controller
   assign beat = DMA_XFER_DONE && st_q == host_regs_pkg::DMA_REQ;
   // completion: count reached one on a beat, or host stop written
   assign dma_end = (beat && count_q == 24'h000001) || (wr_stop && acc.wdata[0]); // R3 R4

   // remaining transfer count; zero loaded means the full 2^24 span
   // a count write is refused while active so a run cannot be corrupted mid-way
   always_ff @(posedge CLK) begin
      if (rst_all) begin
         count_q <= host_regs_pkg::RST_COUNT;
      end else if (wr_count && !dma_act_q) begin
         count_q <= acc.wdata[23:0];
      end else if (beat) begin
         count_q <= count_q - 24'h000001; // R17
      end
   end

   // trigger and activity flag; a write of 0 is ignored
   // completion beats a trigger in the same cycle; the host sees idle and may retrigger
   always_ff @(posedge CLK) begin
      if (rst_all) begin
         trig_q <= host_regs_pkg::RST_FLAG;
         dma_act_q <= host_regs_pkg::RST_FLAG;
      end else if (dma_end) begin
         trig_q <= 1'b0; // R9
         dma_act_q <= 1'b0; // R2
      end else if (wr_trig && acc.wdata[0]) begin
         trig_q <= 1'b1; // R7 R9
         dma_act_q <= 1'b1; // R2
      end
   end

   // request sequencer: gap state negates the line after each beat in no-ack mode
   // the gap lasts one cycle, enough for the host controller to see a fresh edge
   always_comb begin
      st_d = st_q;
      case (st_q)
         host_regs_pkg::DMA_IDLE: begin
            if (trig_q && !dma_end) begin
               st_d = host_regs_pkg::DMA_REQ;
            end
         end
         host_regs_pkg::DMA_REQ: begin
            if (dma_end) begin
               st_d = host_regs_pkg::DMA_IDLE;
            end else if (beat && setup_q[host_regs_pkg::SETUP_NO_ACK_BIT]) begin
               st_d = host_regs_pkg::DMA_GAP; // R16
            end
         end
         host_regs_pkg::DMA_GAP: begin
            st_d = dma_end ? host_regs_pkg::DMA_IDLE : host_regs_pkg::DMA_REQ;
         end
         default: st_d = host_regs_pkg::DMA_IDLE;
      endcase
   end

   // sequencer state register
   always_ff @(posedge CLK) begin
      if (rst_all) begin
         st_q <= host_regs_pkg::DMA_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // request line: masked, or negated while not ready in no-ack or negate mode
   // registered so the host controller never sees a decode glitch as an edge
   always_ff @(posedge CLK) begin
      if (rst_all) begin
         DMA_REQUEST_LINE <= 1'b0;
      end else begin
         DMA_REQUEST_LINE <= st_d == host_regs_pkg::DMA_REQ && !mask_q // R1 R8
            && (ready_s || !(setup_q[host_regs_pkg::SETUP_NO_ACK_BIT] // R16
            || setup_q[host_regs_pkg::SETUP_NEGATE_BIT]));
      end
   end

   // command list activity: start bit sets, stop or completion clears
   // completion or stop wins over a start in the same cycle
   always_ff @(posedge CLK) begin
      if (rst_all) begin
         list_act_q <= host_regs_pkg::RST_FLAG;
      end else if (CMD_LIST_DONE || (wr_lstop && acc.wdata[0])) begin
         list_act_q <= 1'b0; // R5 R6
      end else if (wr_lstart && acc.wdata[0]) begin
         list_act_q <= 1'b1; // R18
      end
   end
   assign CMD_LIST_RUN = list_act_q;
   assign LIST_FIFO_BLOCK = list_act_q; // R18

   // interrupt pending: set wins over a clearing write of 0 in the same cycle
   // test bits only mirror a fault, so any pending write clears them
   always_ff @(posedge CLK) begin
      if (rst_all) begin
         pend_q <= host_regs_pkg::RST_IRQ;
         test_q <= host_regs_pkg::RST_IRQ_TEST;
      end else begin
         pend_q <= (wr_pend ? (pend_q & acc.wdata[4:0]) : pend_q) | IRQ_EVENTS; // R10 R11
         test_q <= (wr_pend ? 2'h0 : test_q)
            | (IRQ_TEST_EVENTS & {2{ev.cmd_error}}); // R12
      end
   end

   // interrupt enable
   // a new enable reaches the output one cycle later, through the output flop
   always_ff @(posedge CLK) begin
      if (rst_all) begin
         en_q <= host_regs_pkg::RST_IRQ;
      end else if (wr_en) begin
         en_q <= acc.wdata[4:0]; // R14
      end
   end

   // registered interrupt output keeps glitches off the cpu line
   always_ff @(posedge CLK) begin
      if (rst_all) begin
         IRQ_OUT <= 1'b0;
      end else begin
         IRQ_OUT <= |(pend_q & en_q); // R13 R20
      end
   end

   // read mux; stop and soft reset read back as 0, unmapped reads 0
   // reads have no side effects, so status polling is safe
   always_comb begin
      rdata_d = 32'h00000000;
      case (acc.addr)
         host_regs_pkg::OFS_DMA_REQUEST_MASK: rdata_d[0] = mask_q;
         host_regs_pkg::OFS_DMA_ACTIVITY: rdata_d[0] = dma_act_q; // R2
         host_regs_pkg::OFS_CMD_LIST_ACTIVITY: rdata_d[0] = list_act_q; // R6
         host_regs_pkg::OFS_DMA_REQUEST_TRIGGER: rdata_d[0] = trig_q;
         host_regs_pkg::OFS_DMA_SETUP: rdata_d[3:0] = setup_q;
         host_regs_pkg::OFS_TRANSFER_COUNT: rdata_d[23:0] = count_q; // R17
         host_regs_pkg::OFS_CMD_LIST_START: rdata_d[0] = list_act_q;
         host_regs_pkg::OFS_IRQ_PENDING: begin
            rdata_d[4:0] = pend_q;
            rdata_d[17:16] = test_q;
         end
         host_regs_pkg::OFS_IRQ_ENABLE: rdata_d[4:0] = en_q;
         default: rdata_d = 32'h00000000; // R21
      endcase
   end

   // read data flop, loaded only on a read so it stands until the next one
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         HOST_RDATA <= 32'h00000000;
      end else if (acc.rd) begin
         HOST_RDATA <= rdata_d;
      end
   end
endmodule // host_dma_irq_control_regs
`default_nettype wire

// [host_dma_irq_control_regs_bench.sv]
// bench: random and directed checks of the host control register block
`timescale 1ns/1ps
`default_nettype none
module host_dma_irq_control_regs_bench;
   logic CLK, RST_B, HOST_RD, HOST_WR, DMA_XFER_DONE, DMA_DATA_READY, CMD_LIST_DONE;
   logic DMA_REQUEST_LINE, CMD_LIST_RUN, LIST_FIFO_BLOCK, IRQ_OUT, SOFT_RESET_PULSE;
   logic [11:0] HOST_ADDR;
   logic [31:0] HOST_WDATA, HOST_RDATA, r;
   logic [4:0] IRQ_EVENTS;
   logic [1:0] IRQ_TEST_EVENTS, slow;
   logic [11:0] ofs [9] = '{12'h005, 12'h006, 12'h008, 12'h009, 12'h010, 12'h018,
      12'h020, 12'h024, 12'h0FC};
   int fails = 0, n_tests = 0, beats = 0, seed = 92239, n, i, k;
   host_dma_irq_control_regs dut_u (.CLK(CLK), .RST_B(RST_B), .HOST_RD(HOST_RD),
      .HOST_WR(HOST_WR), .HOST_ADDR(HOST_ADDR), .HOST_WDATA(HOST_WDATA),
      .HOST_RDATA(HOST_RDATA), .DMA_REQUEST_LINE(DMA_REQUEST_LINE),
      .DMA_XFER_DONE(DMA_XFER_DONE), .DMA_DATA_READY(DMA_DATA_READY),
      .CMD_LIST_DONE(CMD_LIST_DONE), .CMD_LIST_RUN(CMD_LIST_RUN),
      .LIST_FIFO_BLOCK(LIST_FIFO_BLOCK), .IRQ_EVENTS(IRQ_EVENTS),
      .IRQ_TEST_EVENTS(IRQ_TEST_EVENTS), .IRQ_OUT(IRQ_OUT),
      .SOFT_RESET_PULSE(SOFT_RESET_PULSE));
   dma_host_model host_u (.clk(CLK), .rst_b(RST_B), .req(DMA_REQUEST_LINE), .slow(slow),
      .done(DMA_XFER_DONE));
   // 25 MHz clock
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   // beats taken by the host side
   always @(posedge CLK) if (DMA_XFER_DONE === 1'b1) beats++;
   function automatic logic [31:0] exp_pend(input int s);
      return (32'h1 << s) | ((s == 0) ? 32'h00030000 : 32'h0);
   endfunction
   task automatic step;
      @(posedge CLK);
      #1;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // one write edge, then an idle edge so a next call never re-raises the strobe at once
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      HOST_WR = 1'b1;
      HOST_ADDR = a;
      HOST_WDATA = d;
      step();
      HOST_WR = 1'b0;
      step();
   endtask
   // read data is registered, so it is taken just after the edge that takes the strobe
   task automatic rd(input logic [11:0] a);
      HOST_RD = 1'b1;
      HOST_ADDR = a;
      step();
      r = HOST_RDATA;
      HOST_RD = 1'b0;
      step();
   endtask
   // poll the activity flag until it clears; running out counts as a mismatch
   task automatic wait_idle;
      for (i = 0; i < 300 && r !== 32'h0; i++) rd(12'h006);
      if (i == 300) begin
         fails++;
         $display("MISMATCH t=%0t dma never finished", $time);
         wrap_up();
      end
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      chk(r, e);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      {RST_B, HOST_RD, HOST_WR, CMD_LIST_DONE, HOST_ADDR, HOST_WDATA} = '0;
      {IRQ_EVENTS, IRQ_TEST_EVENTS, slow} = '0;
      DMA_DATA_READY = 1'b1;
      repeat (3) @(posedge CLK);
      #1 RST_B = 1'b1;
      foreach (ofs[j]) rc(ofs[j], 32'h0);
      $display("test reset values done");
      // random counts and host latencies; each run must take exactly its count
      for (k = 0; k < 3; k++) begin
         n = 1 + ($random(seed) & 3);
         slow = 2'($random(seed));
         beats = 0;
         wr(12'h000, 32'(n));
         wr(12'h018, 32'h1);
         chk(32'(DMA_REQUEST_LINE), 32'h1);
         rc(12'h006, 32'h1);
         wait_idle();
         chk(32'(beats), 32'(n));
         rc(12'h018, 32'h0);
      end
      $display("test dma runs done");
      // no-ack (setup bit 3) then negate (bit 1): line low while not ready, then 3 beats
      for (k = 0; k < 2; k++) begin
         wr(12'h004, (k == 0) ? 32'h8 : 32'h2);
         DMA_DATA_READY = 1'b0;
         wr(12'h000, 32'h3);
         wr(12'h018, 32'h1);
         repeat (4) step();
         chk(32'(DMA_REQUEST_LINE), 32'h0);
         beats = 0;
         DMA_DATA_READY = 1'b1;
         rc(12'h006, 32'h1);
         wait_idle();
         chk(32'(beats), 32'h3);
      end
      wr(12'h004, 32'h0);
      $display("test dma modes done");
      wr(12'h005, 32'h1);
      wr(12'h000, 32'h2);
      wr(12'h018, 32'h1);
      repeat (8) step();
      chk(32'(DMA_REQUEST_LINE), 32'h0);
      rc(12'h006, 32'h1);
      wr(12'h005, 32'h0);
      step();
      chk(32'(DMA_REQUEST_LINE), 32'h1);
      wr(12'h008, 32'h1);
      chk(32'(DMA_REQUEST_LINE), 32'h0);
      rc(12'h006, 32'h0);
      wr(12'h018, 32'h0);
      rc(12'h018, 32'h0);
      $display("test mask and stop done");
      wr(12'h048, 32'h1);
      chk(32'({CMD_LIST_RUN, LIST_FIFO_BLOCK}), 32'h3);
      rc(12'h010, 32'h1);
      wr(12'h009, 32'h1);
      rc(12'h010, 32'h0);
      wr(12'h048, 32'h1);
      CMD_LIST_DONE = 1'b1;
      step();
      CMD_LIST_DONE = 1'b0;
      rc(12'h010, 32'h0);
      $display("test command list done");
      // each source alone: recorded, held off while disabled, cleared by a 0 write
      for (k = 0; k < 5; k++) begin
         IRQ_EVENTS = 5'(1 << k);
         IRQ_TEST_EVENTS = (k == 0) ? 2'h3 : 2'h0;
         step();
         {IRQ_EVENTS, IRQ_TEST_EVENTS} = '0;
         rc(12'h020, exp_pend(k));
         chk(32'(IRQ_OUT), 32'h0);
         wr(12'h024, 32'h1 << k);
         step();
         chk(32'(IRQ_OUT), 32'h1);
         wr(12'h020, 32'h0);
         step();
         chk(32'(IRQ_OUT), 32'h0);
         rc(12'h020, 32'h0);
         wr(12'h024, 32'h0);
      end
      $display("test interrupts done");
      wr(12'h005, 32'h1);
      // written by hand: the one-cycle pulse is over before a full write task returns
      HOST_WR = 1'b1;
      HOST_ADDR = 12'h02C;
      HOST_WDATA = 32'h1;
      step();
      HOST_WR = 1'b0;
      chk(32'(SOFT_RESET_PULSE), 32'h1);
      step();
      chk(32'(SOFT_RESET_PULSE), 32'h0);
      rc(12'h005, 32'h0);
      $display("test soft reset done");
      wrap_up();
   end
endmodule // host_dma_irq_control_regs_bench
`default_nettype wire

// [host_dma_irq_control_regs_properties.sv]
// checker: port-level properties of the host control register block
`timescale 1ns/1ps
`default_nettype none
module host_dma_irq_control_regs_checker (
   // clock, reset and host access
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic HOST_RD,
   input wire logic HOST_WR,
   input wire logic [11:0] HOST_ADDR,
   input wire logic [31:0] HOST_WDATA,
   input wire logic [31:0] HOST_RDATA,
   // dma handshake, interrupt events and output, soft reset output
   input wire logic DMA_REQUEST_LINE,
   input wire logic DMA_XFER_DONE,
   input wire logic [4:0] IRQ_EVENTS,
   input wire logic IRQ_OUT,
   input wire logic SOFT_RESET_PULSE
);
   logic mask_q;
   logic [4:0] en_q;
   logic [3:0] setup_q;
   logic wr_trig;
   logic wr_stop;
   logic wr_soft_reset_cmd;
   // decoded host writes of the command bits
   assign wr_trig = HOST_WR && HOST_ADDR == 12'h018 && HOST_WDATA[0];
   assign wr_stop = HOST_WR && HOST_ADDR == 12'h008 && HOST_WDATA[0];
   assign wr_soft_reset_cmd = HOST_WR && HOST_ADDR == 12'h02C && HOST_WDATA[0];
   // shadow of mask, enable and setup; soft reset clears them as the block does
   always_ff @(posedge CLK) begin
      if (!RST_B || SOFT_RESET_PULSE) begin
         mask_q <= 1'b0;
         en_q <= 5'h00;
         setup_q <= 4'h0;
      end else if (HOST_WR && HOST_ADDR == 12'h005) begin
         mask_q <= HOST_WDATA[0];
      end else if (HOST_WR && HOST_ADDR == 12'h004) begin
         setup_q <= HOST_WDATA[3:0];
      end else if (HOST_WR && HOST_ADDR == 12'h024) begin
         en_q <= HOST_WDATA[4:0];
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   AST_MASK_HOLDS_LINE: assert property (mask_q && $past(mask_q) |-> !DMA_REQUEST_LINE)
      else $error("request line high while masked");
   AST_MASK_READBACK: assert property (HOST_RD && HOST_ADDR == 12'h005
      |=> HOST_RDATA[0] == $past(mask_q)) else $error("mask readback wrong");
   AST_TRIGGER_RAISES: assert property (wr_trig && !mask_q && !DMA_REQUEST_LINE
      && (setup_q & 4'hA) == 4'h0 && !DMA_XFER_DONE && !SOFT_RESET_PULSE
      ##1 !wr_stop && !DMA_XFER_DONE |=> DMA_REQUEST_LINE)
      else $error("trigger did not raise request");
   AST_STOP_DROPS: assert property (wr_stop |=> !DMA_REQUEST_LINE)
      else $error("stop left request high");
   AST_SOFT_RESET_CMD_PULSE: assert property (wr_soft_reset_cmd |=> SOFT_RESET_PULSE ##1 !SOFT_RESET_PULSE)
      else $error("soft reset pulse wrong");
   AST_SOFT_RESET_CMD_CAUSE: assert property ($rose(SOFT_RESET_PULSE) |-> $past(wr_soft_reset_cmd))
      else $error("soft reset pulse without write");
   AST_IRQ_RAISE: assert property ((|(IRQ_EVENTS & en_q)) && !HOST_WR && !SOFT_RESET_PULSE
      ##1 !HOST_WR && !SOFT_RESET_PULSE |=> IRQ_OUT) else $error("enabled event lost");
   AST_IRQ_MASKED: assert property ($past(en_q) == 5'h00 |-> !IRQ_OUT)
      else $error("interrupt with all sources disabled");
   AST_RSVD_ZERO: assert property (HOST_RD && HOST_ADDR inside {12'h005, 12'h006,
      12'h008, 12'h009, 12'h010, 12'h018, 12'h02C} |=> HOST_RDATA[31:1] == 31'h0)
      else $error("reserved read bits not zero");
endmodule // host_dma_irq_control_regs_checker
bind host_dma_irq_control_regs host_dma_irq_control_regs_checker chk_u (.CLK, .RST_B,
   .HOST_RD, .HOST_WR, .HOST_ADDR, .HOST_WDATA, .HOST_RDATA, .DMA_REQUEST_LINE,
   .DMA_XFER_DONE, .IRQ_EVENTS, .IRQ_OUT, .SOFT_RESET_PULSE);
`default_nettype wire

// [host_regs_pkg.sv]
// package: offsets, reset values, field layout and types for the host control register block
package host_regs_pkg;
   // register byte offsets from the host base address
   localparam logic [11:0] OFS_DMA_REQUEST_MASK = 12'h005;
   localparam logic [11:0] OFS_DMA_ACTIVITY = 12'h006;
   localparam logic [11:0] OFS_DMA_STOP = 12'h008;
   localparam logic [11:0] OFS_CMD_LIST_STOP = 12'h009;
   localparam logic [11:0] OFS_CMD_LIST_ACTIVITY = 12'h010;
   localparam logic [11:0] OFS_DMA_REQUEST_TRIGGER = 12'h018;
   localparam logic [11:0] OFS_IRQ_PENDING = 12'h020;
   localparam logic [11:0] OFS_IRQ_ENABLE = 12'h024;
   localparam logic [11:0] OFS_SOFT_RESET = 12'h02C;
   localparam logic [11:0] OFS_DMA_SETUP = 12'h004;
   localparam logic [11:0] OFS_TRANSFER_COUNT = 12'h000;
   localparam logic [11:0] OFS_CMD_LIST_START = 12'h048;

   // field positions and widths
   localparam int IRQ_SRC_N = 5;
   localparam int IRQ_TEST_LO = 16;
   localparam int SETUP_NO_ACK_BIT = 3;
   localparam int SETUP_NEGATE_BIT = 1;
   localparam int COUNT_W = 24;

   // values after reset
   localparam logic RST_FLAG = 1'b0;
   localparam logic [IRQ_SRC_N-1:0] RST_IRQ = 5'h00;
   localparam logic [1:0] RST_IRQ_TEST = 2'h0;
   localparam logic [3:0] RST_SETUP = 4'h0;
   localparam logic [COUNT_W-1:0] RST_COUNT = 24'h000000;

   // interrupt source order, bit index in pending and enable
   typedef enum logic [2:0] {
      SRC_CMD_ERROR = 3'h0,
      SRC_CMD_DONE = 3'h1,
      SRC_VSYNC = 3'h2,
      SRC_FRAME_SYNC = 3'h3,
      SRC_EXT_SYNC_ERROR = 3'h4
   } irq_src_t;

   // external request state machine, one bit changes per step except gap to idle
   typedef enum logic [1:0] {
      DMA_IDLE = 2'b00,
      DMA_REQ = 2'b01,
      DMA_GAP = 2'b11
   } dma_state_t;

   // host register access bundle
   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [31:0] wdata;
   } host_access_t;

   // raised interrupt source pulses
   typedef struct packed {
      logic ext_sync_error;
      logic frame_sync;
      logic vsync;
      logic cmd_done;
      logic cmd_error;
   } irq_events_t;
endpackage
